// ===== design/wss_seq_top.sv
/*
 * wss_seq_top: eight-slot waveform sequencer with AXI4-Lite registers.
 * Assumes an outside playback engine that plays wave_index_o after play_start_o
 * and pulses wave_done_i when the waveform ends.
 */
// The AXI4-Lite register port is this design's own decision.
// Summary of operation
// - delay-select slot idles, no waveform driven
// - delay lasts entry times 10 ms
// - clear delay-select means entry is waveform
// - entry bits six..zero index the library
// - go starts playback at first slot
// - waveform done advances to next slot
// - stop after eighth slot at most
// - zero entry stops the sequence
// - slots reset to zero, read/write
`timescale 1ns/1ps
`default_nettype none
module wss_seq_top #(
    parameter int STEP_CYCLES = wss_pkg::DELAY_STEP_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [wss_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [wss_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic play_start_o,
    output logic [6:0] wave_index_o,
    input wire logic wave_done_i,
    output logic busy_o
);
    import wss_pkg::*;
    localparam int TICK_W = $clog2(STEP_CYCLES + 1);
    ////////////////////////////////////////////////////////////////////////////
    // slot storage
    wss_slot_if slot_if ();
    wss_slot_mem u_mem (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .slot_if(slot_if)
    );
    function automatic logic is_slot(input logic [ADDR_W-1:0] addr);
        return addr[7:2] >= IDX_SLOT_FIRST && addr[7:2] <= IDX_SLOT_LAST;
    endfunction
    function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] addr);
        return 3'(addr[7:2] - IDX_SLOT_FIRST);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // axi write channel
    logic aw_full_reg, aw_full_next;
    logic w_full_reg, w_full_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_lane_reg, w_lane_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic wr_do;
    logic go_pulse;
    always_comb begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_lane_next = w_lane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
        go_pulse = 1'b0;
        if (s_axi_awvalid_i && !aw_full_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_full_reg) begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata_i[7:0];
            w_lane_next = s_axi_wstrb_i[0];
        end
        if (wr_do) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_SLVERR;
            if (is_slot(aw_addr_reg) || aw_addr_reg[7:2] == IDX_CTRL || aw_addr_reg[7:2] == IDX_STATUS) begin
                bresp_next = RESP_OKAY;
            end
            go_pulse = w_lane_reg && aw_addr_reg[7:2] == IDX_CTRL && w_data_reg[CTRL_GO_BIT];
        end
        if (bvalid_reg && s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
    end
    assign slot_if.sw_we = wr_do && w_lane_reg && is_slot(aw_addr_reg);
    assign slot_if.sw_waddr = slot_of(aw_addr_reg);
    assign slot_if.sw_wdata = w_data_reg;
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_lane_reg <= w_lane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi read channel: three edges from address to data, the slot read is registered
    logic [1:0] rd_phase_reg, rd_phase_next;
    logic [ADDR_W-1:0] ar_addr_reg, ar_addr_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] status_word;
    always_comb begin
        rd_phase_next = rd_phase_reg;
        ar_addr_next = ar_addr_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rd_phase_reg == 2'h0 && !rvalid_reg && s_axi_arvalid_i) begin
            ar_addr_next = s_axi_araddr_i;
            rd_phase_next = 2'h1;
        end else if (rd_phase_reg == 2'h1) begin
            rd_phase_next = 2'h2;
        end else if (rd_phase_reg == 2'h2) begin
            rd_phase_next = 2'h0;
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            if (is_slot(ar_addr_reg)) begin
                rdata_next = {24'h000000, slot_if.sw_rdata};
            end else if (ar_addr_reg[7:2] == IDX_CTRL) begin
                rdata_next = {31'h00000000, busy_o};
            end else if (ar_addr_reg[7:2] == IDX_STATUS) begin
                rdata_next = status_word;
            end else begin
                rdata_next = 32'h00000000;
                rresp_next = RESP_SLVERR;
            end
        end
        if (rvalid_reg && s_axi_rready_i) begin
            rvalid_next = 1'b0;
        end
    end
    assign slot_if.sw_raddr = slot_of(ar_addr_reg);
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rd_phase_reg <= 2'h0;
            ar_addr_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end else begin
            rd_phase_reg <= rd_phase_next;
            ar_addr_reg <= ar_addr_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    wss_state_t state_reg, state_next;
    logic [2:0] ptr_reg, ptr_next;
    logic [6:0] delay_left_reg, delay_left_next;
    logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic play_reg, play_next;
    logic [6:0] index_reg, index_next;
    logic busy_reg, busy_next;
    logic tick;
    logic [7:0] slot_data;
    assign slot_data = slot_if.sq_rdata;
    assign slot_if.sq_raddr = ptr_reg;
    // one tick per delay step; counter cleared when a delay slot is decoded so each step is whole
    assign tick = state_reg == S_DELAY && tick_cnt_reg == TICK_W'(STEP_CYCLES - 1);
    always_comb begin
        state_next = state_reg;
        ptr_next = ptr_reg;
        delay_left_next = delay_left_reg;
        tick_cnt_next = tick_cnt_reg;
        play_next = 1'b0;
        index_next = index_reg;
        if (state_reg == S_DELAY) begin
            tick_cnt_next = tick ? '0 : TICK_W'(tick_cnt_reg + 1'b1);
        end
        case (state_reg)
            S_IDLE: begin
                if (go_pulse) begin
                    ptr_next = 3'h0;
                    state_next = S_FETCH;
                end
            end
            S_FETCH: begin
                state_next = S_DECODE;
            end
            S_DECODE: begin
                if (slot_data[SLOT_DELAY_BIT]) begin
                    delay_left_next = slot_data[SLOT_ENTRY_MSB:0];
                    tick_cnt_next = '0;
                    state_next = S_DELAY;
                end else if (slot_data[SLOT_ENTRY_MSB:0] == 7'h00) begin
                    state_next = S_IDLE;
                end else begin
                    index_next = slot_data[SLOT_ENTRY_MSB:0];
                    play_next = 1'b1;
                    state_next = S_PLAY;
                end
            end
            S_PLAY, S_DELAY: begin
                if ((state_reg == S_PLAY && wave_done_i) || (state_reg == S_DELAY && delay_left_reg == 7'h00)) begin
                    if (ptr_reg == 3'(SLOT_COUNT - 1)) begin
                        state_next = S_IDLE;
                    end else begin
                        ptr_next = 3'(ptr_reg + 1'b1);
                        state_next = S_FETCH;
                    end
                end else if (state_reg == S_DELAY && tick) begin
                    delay_left_next = 7'(delay_left_reg - 1'b1);
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        busy_next = state_next != S_IDLE;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_reg <= S_IDLE;
            ptr_reg <= 3'h0;
            delay_left_reg <= 7'h00;
            tick_cnt_reg <= '0;
            play_reg <= 1'b0;
            index_reg <= 7'h00;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
            delay_left_reg <= delay_left_next;
            tick_cnt_reg <= tick_cnt_next;
            play_reg <= play_next;
            index_reg <= index_next;
            busy_reg <= busy_next;
        end
    end

    always_comb begin
        status_word = 32'h00000000;
        status_word[STAT_BUSY_BIT] = busy_reg;
        status_word[STAT_DELAY_BIT] = state_reg == S_DELAY;
        status_word[STAT_PTR_LSB +: 3] = ptr_reg;
    end
    assign s_axi_awready_o = !aw_full_reg;
    assign s_axi_wready_o = !w_full_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = rd_phase_reg == 2'h0 && !rvalid_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign play_start_o = play_reg;
    assign wave_index_o = index_reg;
    assign busy_o = busy_reg;
    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_play_issued;
        play_start_o && state_reg == S_PLAY;
    endsequence
    property p_delay_idle;
        (state_reg == S_DECODE && slot_data[7]) |=> (state_reg == S_DELAY && !play_start_o);
    endproperty
    a_delay_idle: assert property (p_delay_idle) else $error("delay slot drove a waveform");
    property p_delay_step;
        (state_reg == S_DELAY && delay_left_reg != 7'h00 && tick) |=> delay_left_reg == 7'($past(delay_left_reg) - 1);
    endproperty
    a_delay_step: assert property (p_delay_step) else $error("delay count not stepped on tick");
    property p_wave_play;
        (state_reg == S_DECODE && !slot_data[7] && slot_data[6:0] != 7'h00) |=> s_play_issued;
    endproperty
    a_wave_play: assert property (p_wave_play) else $error("waveform slot not played");
    property p_wave_index;
        (state_reg == S_DECODE && !slot_data[7] && slot_data[6:0] != 7'h00) |=> wave_index_o == $past(slot_data[6:0]);
    endproperty
    a_wave_index: assert property (p_wave_index) else $error("wrong waveform index");
    // busy is checked at fetch: a zero first slot legally drops it two cycles later
    property p_go_start;
        (state_reg == S_IDLE && go_pulse) |=> (state_reg == S_FETCH && ptr_reg == 3'h0 && busy_o)
            ##1 (state_reg == S_DECODE && ptr_reg == 3'h0);
    endproperty
    a_go_start: assert property (p_go_start) else $error("go did not start at first slot");
    property p_advance;
        (state_reg == S_PLAY && wave_done_i && ptr_reg != 3'h7)
            |=> (state_reg == S_FETCH && ptr_reg == 3'($past(ptr_reg) + 1));
    endproperty
    a_advance: assert property (p_advance) else $error("sequencer did not advance");
    property p_last_slot;
        (state_reg == S_PLAY && wave_done_i && ptr_reg == 3'h7) |=> (state_reg == S_IDLE && !busy_o);
    endproperty
    a_last_slot: assert property (p_last_slot) else $error("sequencer ran past eighth slot");
    property p_zero_stop;
        (state_reg == S_DECODE && slot_data == 8'h00) |=> (state_reg == S_IDLE && !play_start_o && !busy_o);
    endproperty
    a_zero_stop: assert property (p_zero_stop) else $error("zero entry did not stop");
    property p_tick_restart;
        (state_reg == S_DECODE && slot_data[7]) |=> tick_cnt_reg == '0;
    endproperty
    a_tick_restart: assert property (p_tick_restart) else $error("delay step counter not restarted");
endmodule
`default_nettype wire

// ===== pkg/wss_pkg.sv
/*
 * wss_pkg: constants of the waveform sequence slot block.
 * Assumes a 20 MHz core clock and an AXI4-Lite register bus, 32-bit data.
 */
package wss_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int DELAY_STEP_MS = 10;
    localparam int DELAY_STEP_CYC = (CLK_HZ / 1000) * DELAY_STEP_MS;

    localparam int ADDR_W = 8;
    localparam int SLOT_COUNT = 8;
    localparam int SLOT_AW = 3;
    localparam int SLOT_W = 8;

    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h0C;
    localparam logic [5:0] IDX_SLOT_FIRST = 6'h0F;
    localparam logic [5:0] IDX_SLOT_THREE = 6'h11;
    localparam logic [5:0] IDX_SLOT_FOUR = 6'h12;
    localparam logic [5:0] IDX_SLOT_LAST = 6'h16;
    localparam logic [5:0] IDX_STATUS = 6'h17;

    // slot fields
    localparam int SLOT_DELAY_BIT = 7;
    localparam int SLOT_ENTRY_MSB = 6;
    localparam logic [7:0] SLOT_RESET = 8'h00;

    // control and status fields
    localparam int CTRL_GO_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DELAY_BIT = 1;
    localparam int STAT_PTR_LSB = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        S_IDLE,
        S_FETCH,
        S_DECODE,
        S_PLAY,
        S_DELAY
    } wss_state_t;
endpackage

// ===== pkg/wss_slot_if.sv
/*
 * wss_slot_if: access to the eight sequence slots.
 * Assumes one clock; both read ports return data one edge after the address.
 */
`timescale 1ns/1ps
`default_nettype none
interface wss_slot_if;
    logic sw_we;
    logic [2:0] sw_waddr;
    logic [7:0] sw_wdata;
    logic [2:0] sw_raddr;
    logic [7:0] sw_rdata;
    logic [2:0] sq_raddr;
    logic [7:0] sq_rdata;
    modport mem (input sw_we, sw_waddr, sw_wdata, sw_raddr, sq_raddr, output sw_rdata, sq_rdata);
    modport user (output sw_we, sw_waddr, sw_wdata, sw_raddr, sq_raddr, input sw_rdata, sq_rdata);
endinterface
`default_nettype wire

// ===== design/wss_slot_mem.sv
/*
 * wss_slot_mem: eight 8-bit sequence slots, one write port, two registered reads.
 * Assumes synchronous active-low reset from the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module wss_slot_mem (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    wss_slot_if.mem slot_if
);
    import wss_pkg::*;

    logic [7:0] slot_reg [SLOT_COUNT];
    logic [7:0] slot_next [SLOT_COUNT];
    logic [7:0] sw_rdata_reg;
    logic [7:0] sq_rdata_reg;

    always_comb begin
        for (int i = 0; i < SLOT_COUNT; i++) begin
            slot_next[i] = slot_reg[i];
        end
        if (slot_if.sw_we) begin
            slot_next[slot_if.sw_waddr] = slot_if.sw_wdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < SLOT_COUNT; i++) begin
                slot_reg[i] <= SLOT_RESET;
            end
            sw_rdata_reg <= 8'h00;
            sq_rdata_reg <= 8'h00;
        end else begin
            slot_reg <= slot_next;
            sw_rdata_reg <= slot_reg[slot_if.sw_raddr];
            sq_rdata_reg <= slot_reg[slot_if.sq_raddr];
        end
    end

    assign slot_if.sw_rdata = sw_rdata_reg;
    assign slot_if.sq_rdata = sq_rdata_reg;

    property p_slots_reset;
        @(posedge core_clk_i) $rose(rst_b_i) |-> (slot_reg[2] == 8'h00 && slot_reg[3] == 8'h00);
    endproperty
    a_slots_reset: assert property (p_slots_reset) else $error("slot three or four not cleared by reset");
endmodule
`default_nettype wire

// ===== tb/wss_seq_top_tb_top.sv
/*
 * wss_seq_top_tb_top: self-checking bench for the waveform sequence slot block.
 * Assumes the bench plays the AXI4-Lite master and the playback engine itself.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module wss_seq_top_tb_top;
import wss_pkg::*;
// short delay step so a delay slot costs a handful of cycles
localparam int STEP = 4;
localparam int TIMEOUT_CYC = 6000;
logic core_clk_i = 1'b0;
logic rst_b_i = 1'b0;
logic [7:0] awaddr = 8'h00;
logic awvalid = 1'b0;
logic [31:0] wdata = 32'h0;
logic wvalid = 1'b0;
logic bready = 1'b0;
logic [7:0] araddr = 8'h00;
logic arvalid = 1'b0;
logic rready = 1'b0;
logic wave_done = 1'b0;
logic awready, wready, bvalid, arready, rvalid, play_start, busy;
logic [1:0] bresp, rresp;
logic [31:0] rdata;
logic [6:0] wave_index;
int num_errors = 0;
int n_compared = 0;
int cyc = 0;
logic [6:0] q_idx[$];
int q_cyc[$];
logic [1:0] rsp;
logic [31:0] rd;
int s1, d1, s2, d2, s3, d3;

wss_seq_top #(.STEP_CYCLES(STEP)) uut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .play_start_o(play_start), .wave_index_o(wave_index), .wave_done_i(wave_done), .busy_o(busy)
);

initial begin
    forever #25 core_clk_i = ~core_clk_i;
end

////////////////////////////////////////////////////////////////////////////////
// cycle count, timeout and play monitor
// play pulses are logged mid-cycle so the waiting task never races the log
always @(negedge core_clk_i) begin
    if (play_start === 1'b1) begin
        q_idx.push_back(wave_index);
        q_cyc.push_back(cyc);
    end
end
always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc >= TIMEOUT_CYC) begin
        num_errors++;
        summarize();
    end
end

task automatic summarize();
    if (num_errors == 0 && n_compared > 0) begin
        $display("RESULT: PASS");
    end else begin
        $display("RESULT: FAIL");
    end
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////////
// bus tasks: requests held until their ready is sampled high
task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge core_clk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
        @(posedge core_clk_i);
        if (!aw_done && awready === 1'b1) begin
            aw_done = 1;
            awvalid <= 1'b0;
        end
        if (!w_done && wready === 1'b1) begin
            w_done = 1;
            wvalid <= 1'b0;
        end
    end
    while (bvalid !== 1'b1) @(posedge core_clk_i);
    r = bresp;
    bready <= 1'b0;
endtask

task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge core_clk_i);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
endtask

function automatic logic [7:0] slot_addr(input int k);
    return 8'(4 * (int'(IDX_SLOT_FIRST) + k));
endfunction

// waits for the next waveform start, checks its index, then ends it
task automatic play_one(input logic [6:0] idx, output int st, output int dn);
    logic [6:0] got;
    while (q_idx.size() == 0) @(posedge core_clk_i);
    got = q_idx.pop_front();
    `CHECK(got, idx)
    st = q_cyc.pop_front();
    @(posedge core_clk_i);
    wave_done <= 1'b1;
    @(posedge core_clk_i);
    dn = cyc;
    wave_done <= 1'b0;
endtask

task automatic go_and_check();
    axi_write(8'(4 * int'(IDX_CTRL)), 32'h0000_0001, rsp);
    `CHECK(rsp, RESP_OKAY)
    `CHECK(busy, 1'b1)
endtask

task automatic expect_stopped();
    repeat (10) @(posedge core_clk_i);
    `CHECK(busy, 1'b0)
    `CHECK(q_idx.size(), 0)
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;

    // reset values and read/write of slots three and four
    axi_read(8'(4 * int'(IDX_SLOT_THREE)), rd, rsp);
    `CHECK(rd, 32'h0000_0000)
    axi_read(8'(4 * int'(IDX_SLOT_FOUR)), rd, rsp);
    `CHECK(rd, 32'h0000_0000)
    axi_write(8'(4 * int'(IDX_SLOT_THREE)), 32'h0000_00FF, rsp);
    `CHECK(rsp, RESP_OKAY)
    axi_read(8'(4 * int'(IDX_SLOT_THREE)), rd, rsp);
    `CHECK(rd, 32'h0000_00FF)
    axi_read(8'(4 * int'(IDX_SLOT_FOUR)), rd, rsp);
    `CHECK(rd, 32'h0000_0000)
    axi_write(8'(4 * int'(IDX_SLOT_FOUR)), 32'h0000_0080, rsp);
    axi_read(8'(4 * int'(IDX_SLOT_FOUR)), rd, rsp);
    `CHECK(rd, 32'h0000_0080)
    axi_write(8'(4 * int'(IDX_SLOT_FOUR)), 32'h0000_007F, rsp);
    axi_read(8'(4 * int'(IDX_SLOT_FOUR)), rd, rsp);
    `CHECK(rd, 32'h0000_007F)

    // unmapped address answers with an error and zero data
    axi_read(8'h60, rd, rsp);
    `CHECK(rsp, RESP_SLVERR)
    `CHECK(rd, 32'h0000_0000)
    axi_write(8'h60, 32'h0000_0055, rsp);
    `CHECK(rsp, RESP_SLVERR)

    // wave, delay 1, wave in slot three, delay 3 in slot four, wave, zero stop
    axi_write(slot_addr(0), 32'h0000_0005, rsp);
    axi_write(slot_addr(1), 32'h0000_0081, rsp);
    axi_write(slot_addr(2), 32'h0000_002A, rsp);
    axi_write(slot_addr(3), 32'h0000_0083, rsp);
    axi_write(slot_addr(4), 32'h0000_0011, rsp);
    axi_write(slot_addr(5), 32'h0000_0000, rsp);
    go_and_check();
    play_one(7'h05, s1, d1);
    play_one(7'h2A, s2, d2);
    play_one(7'h11, s3, d3);
    // overheads cancel, so the difference shows the pure step count
    `CHECK((s3 - d2) - (s2 - d1), 2 * STEP)
    `CHECK((s2 - d1) >= STEP, 1'b1)
    expect_stopped();

    // eight waveform slots play, then the sequence ends on its own
    for (int k = 0; k < SLOT_COUNT; k++) begin
        axi_write(slot_addr(k), 32'(k + 1), rsp);
    end
    go_and_check();
    // first slot waits in play until the engine answers, so busy and pointer stand still
    axi_read(8'(4 * int'(IDX_CTRL)), rd, rsp);
    `CHECK(rd, 32'h0000_0001)
    axi_read(8'(4 * int'(IDX_STATUS)), rd, rsp);
    `CHECK(rd, 32'h0000_0001)
    for (int k = 0; k < SLOT_COUNT; k++) begin
        play_one(7'(k + 1), s1, d1);
    end
    expect_stopped();
    axi_read(8'(4 * int'(IDX_STATUS)), rd, rsp);
    `CHECK(rd, 32'h0000_0070)
    axi_read(8'(4 * int'(IDX_CTRL)), rd, rsp);
    `CHECK(rd, 32'h0000_0000)
    summarize();
end
endmodule
`default_nettype wire
